// ### include/prc_pkg.sv
package prc_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [15:0] PRC_OFS_RESTART = 16'hFE88;
    localparam logic [15:0] PRC_OFS_ADC_RATE = 16'hFE89;
    localparam logic [15:0] PRC_OFS_WARN = 16'hFE8A;

    // Values after reset; the ADC rate starts at the fastest setting
    localparam logic [7:0] PRC_RST_RESTART = 8'h00;
    localparam logic [7:0] PRC_RST_ADC_RATE = 8'h00;
    localparam logic [7:0] PRC_RST_WARN = 8'h00;
    localparam logic [7:0] PRC_RST_RDATA = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PRC_GO_A_BIT = 0;
    localparam int PRC_GO_B_BIT = 1;
    localparam int PRC_DLY_LSB = 2;
    localparam int PRC_ADC_LSB = 0;
    localparam int PRC_W1_THR_LSB = 0;
    localparam int PRC_W1_PG_BIT = 2;
    localparam int PRC_W1_NODEB_BIT = 3;
    localparam int PRC_W2_THR_LSB = 4;
    localparam int PRC_W2_PG_BIT = 6;
    localparam int PRC_W2_NODEB_BIT = 7;

    // ==========================================================
    // Timing: times in microseconds, counts at 40 MHz
    // ==========================================================
    localparam int PRC_CLK_MHZ = 40;
    localparam int PRC_RESTART_500MS_US = 500_000;
    localparam int PRC_RESTART_1S_US = 1_000_000;
    localparam int PRC_RESTART_2S_US = 2_000_000;
    localparam int PRC_ADC_10P5_US = 10_500;
    localparam int PRC_ADC_52P4_US = 52_400;
    localparam int PRC_ADC_104P9_US = 104_900;
    localparam int PRC_ADC_209P7_US = 209_700;
    localparam int PRC_DEB_100MS_US = 100_000;
    localparam int PRC_RESTART_500MS_CYC = PRC_RESTART_500MS_US * PRC_CLK_MHZ;
    localparam int PRC_RESTART_1S_CYC = PRC_RESTART_1S_US * PRC_CLK_MHZ;
    localparam int PRC_RESTART_2S_CYC = PRC_RESTART_2S_US * PRC_CLK_MHZ;
    localparam int PRC_ADC_10P5_CYC = PRC_ADC_10P5_US * PRC_CLK_MHZ;
    localparam int PRC_ADC_52P4_CYC = PRC_ADC_52P4_US * PRC_CLK_MHZ;
    localparam int PRC_ADC_104P9_CYC = PRC_ADC_104P9_US * PRC_CLK_MHZ;
    localparam int PRC_ADC_209P7_CYC = PRC_ADC_209P7_US * PRC_CLK_MHZ;
    localparam int PRC_DEB_100MS_CYC = PRC_DEB_100MS_US * PRC_CLK_MHZ;

    // Widths: 27 bits hold the 2 s count of 80 million cycles
    localparam int PRC_CNT_W = 27;
    localparam int PRC_TEMP_W = 12;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [0:0] {
        PRC_SEQ_IDLE,
        PRC_SEQ_OFF
    } prc_seq_state_t;

    // Status flags of one channel from the protection logic
    typedef struct packed {
        logic undervoltage;
        logic supply_off;
        logic softstart_filter;
    } prc_chan_flags_t;

    typedef struct packed {
        logic [PRC_CNT_W-1:0] cnt;
        logic flag;
    } prc_deb_st_t;

    typedef struct packed {
        prc_seq_state_t state;
        logic [PRC_CNT_W-1:0] cnt;
        logic off;
        logic begun;
    } prc_seq_st_t;

    typedef struct packed {
        logic [7:0] restart_ctrl;
        logic [7:0] adc_rate;
        logic [7:0] warn_cfg;
        logic [7:0] rdata;
        logic [PRC_CNT_W-1:0] adc_cnt;
        logic adc_strobe;
        logic pg_fault_a;
        logic pg_fault_b;
        logic pg_pin_a;
        logic pg_pin_b;
    } prc_top_st_t;

    // Warning level: protection level plus one to four sense LSBs
    function automatic logic [PRC_TEMP_W:0] prc_warn_level(
        input logic [PRC_TEMP_W-1:0] protect,
        input logic [1:0] margin_sel
    );
        return {1'b0, protect} + {{(PRC_TEMP_W-1){1'b0}}, margin_sel}
            + {{PRC_TEMP_W{1'b0}}, 1'b1};
    endfunction

endpackage

// ### rtl/prc_debounce.sv
`timescale 1ns/1ps
module prc_debounce
    import prc_pkg::*;
#(
    parameter logic [PRC_CNT_W-1:0] DEB_CYC = PRC_CNT_W'(PRC_DEB_100MS_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cond,
    input wire logic bypass,
    output logic flag
);

    prc_deb_st_t st;
    prc_deb_st_t next_st;

    // ==========================================================
    // Persistence filter
    // ==========================================================
    // Any drop of the condition restarts the whole interval
    always_comb begin
        next_st = st;
        if (!cond) begin
            next_st.cnt = '0;
            next_st.flag = 1'b0;
        end else if (bypass) begin
            next_st.flag = 1'b1;
        end else if (st.cnt >= DEB_CYC - 1'b1) begin
            next_st.flag = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;

endmodule

// ### rtl/prc_restart_seq.sv
`timescale 1ns/1ps
module prc_restart_seq
    import prc_pkg::*;
#(
    parameter logic [PRC_CNT_W-1:0] DLY1_CYC = PRC_CNT_W'(PRC_RESTART_500MS_CYC),
    parameter logic [PRC_CNT_W-1:0] DLY2_CYC = PRC_CNT_W'(PRC_RESTART_1S_CYC),
    parameter logic [PRC_CNT_W-1:0] DLY3_CYC = PRC_CNT_W'(PRC_RESTART_2S_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic [1:0] delay_sel,
    output logic supply_off,
    output logic begun
);

    prc_seq_st_t st;
    prc_seq_st_t next_st;

    // ==========================================================
    // Off-then-restart sequence
    // ==========================================================
    // Delay is latched at the start so a rewrite cannot stretch it
    always_comb begin
        next_st = st;
        next_st.begun = 1'b0;
        unique case (st.state)
            PRC_SEQ_IDLE: begin
                if (go) begin
                    next_st.state = PRC_SEQ_OFF;
                    next_st.off = 1'b1;
                    next_st.begun = 1'b1;
                    unique case (delay_sel)
                        2'h0: next_st.cnt = '0;
                        2'h1: next_st.cnt = DLY1_CYC;
                        2'h2: next_st.cnt = DLY2_CYC;
                        2'h3: next_st.cnt = DLY3_CYC;
                    endcase
                end
            end
            PRC_SEQ_OFF: begin
                if (st.cnt == '0) begin
                    next_st.state = PRC_SEQ_IDLE;
                    next_st.off = 1'b0;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign supply_off = st.off;
    assign begun = st.begun;

endmodule

// ### rtl/prc_top.sv
`timescale 1ns/1ps
module prc_top
    import prc_pkg::*;
#(
    parameter logic [PRC_CNT_W-1:0] RESTART_500MS_CYC =
        PRC_CNT_W'(PRC_RESTART_500MS_CYC),
    parameter logic [PRC_CNT_W-1:0] RESTART_1S_CYC =
        PRC_CNT_W'(PRC_RESTART_1S_CYC),
    parameter logic [PRC_CNT_W-1:0] RESTART_2S_CYC =
        PRC_CNT_W'(PRC_RESTART_2S_CYC),
    parameter logic [PRC_CNT_W-1:0] ADC_10P5_CYC =
        PRC_CNT_W'(PRC_ADC_10P5_CYC),
    parameter logic [PRC_CNT_W-1:0] ADC_52P4_CYC =
        PRC_CNT_W'(PRC_ADC_52P4_CYC),
    parameter logic [PRC_CNT_W-1:0] ADC_104P9_CYC =
        PRC_CNT_W'(PRC_ADC_104P9_CYC),
    parameter logic [PRC_CNT_W-1:0] ADC_209P7_CYC =
        PRC_CNT_W'(PRC_ADC_209P7_CYC),
    parameter logic [PRC_CNT_W-1:0] DEB_100MS_CYC =
        PRC_CNT_W'(PRC_DEB_100MS_CYC)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [PRC_TEMP_W-1:0] temp_sense_first,
    input wire logic [PRC_TEMP_W-1:0] temp_sense_second,
    input wire logic [PRC_TEMP_W-1:0] overtemp_protect_first,
    input wire logic [PRC_TEMP_W-1:0] overtemp_protect_second,
    input wire prc_chan_flags_t flags_chan_a,
    input wire prc_chan_flags_t flags_chan_b,
    input wire logic config_crc_flag,
    output logic supply_off_chan_a,
    output logic supply_off_chan_b,
    output logic current_adc_refresh,
    output logic temp_warn_first,
    output logic temp_warn_second,
    output logic power_good_fault_chan_a,
    output logic power_good_fault_chan_b,
    output logic power_good_pin_chan_a,
    output logic power_good_pin_chan_b
);

    // ==========================================================
    // State
    // ==========================================================
    prc_top_st_t st;
    prc_top_st_t next_st;

    logic seq_off_a;
    logic seq_off_b;
    logic begun_a;
    logic begun_b;
    logic warn_raw_first;
    logic warn_raw_second;
    logic warn_first;
    logic warn_second;
    logic [PRC_CNT_W-1:0] adc_period;
    logic wr_restart;
    logic wr_adc;
    logic wr_warn;

    // ==========================================================
    // Address decode
    // ==========================================================
    // Only full 16-bit matches select a register
    assign wr_restart = reg_wr && (reg_addr == PRC_OFS_RESTART);
    assign wr_adc = reg_wr && (reg_addr == PRC_OFS_ADC_RATE);
    assign wr_warn = reg_wr && (reg_addr == PRC_OFS_WARN);

    // ==========================================================
    // Restart sequencers, one per channel
    // ==========================================================
    // Channel A from go bit 0 and the shared delay
    prc_restart_seq #(
        .DLY1_CYC(RESTART_500MS_CYC),
        .DLY2_CYC(RESTART_1S_CYC),
        .DLY3_CYC(RESTART_2S_CYC)
    ) u_seq_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .go(st.restart_ctrl[PRC_GO_A_BIT]),
        .delay_sel(st.restart_ctrl[PRC_DLY_LSB+:2]),
        .supply_off(seq_off_a),
        .begun(begun_a)
    );

    // Channel B from go bit 1 and the same delay
    prc_restart_seq #(
        .DLY1_CYC(RESTART_500MS_CYC),
        .DLY2_CYC(RESTART_1S_CYC),
        .DLY3_CYC(RESTART_2S_CYC)
    ) u_seq_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .go(st.restart_ctrl[PRC_GO_B_BIT]),
        .delay_sel(st.restart_ctrl[PRC_DLY_LSB+:2]),
        .supply_off(seq_off_b),
        .begun(begun_b)
    );

    // Sequencer outputs are flops
    assign supply_off_chan_a = seq_off_a;
    assign supply_off_chan_b = seq_off_b;

    // ==========================================================
    // Temperature warning comparators
    // ==========================================================
    // Sense codes come from same-clock ADC logic, so no synchroniser
    assign warn_raw_first = {1'b0, temp_sense_first} >= prc_warn_level(
        overtemp_protect_first,
        st.warn_cfg[PRC_W1_THR_LSB+:2]);
    assign warn_raw_second = {1'b0, temp_sense_second} >= prc_warn_level(
        overtemp_protect_second,
        st.warn_cfg[PRC_W2_THR_LSB+:2]);

    // First warning filter
    prc_debounce #(
        .DEB_CYC(DEB_100MS_CYC)
    ) u_deb_first (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(warn_raw_first),
        .bypass(st.warn_cfg[PRC_W1_NODEB_BIT]),
        .flag(warn_first)
    );

    // Second warning filter
    prc_debounce #(
        .DEB_CYC(DEB_100MS_CYC)
    ) u_deb_second (
        .clk(clk),
        .sys_rst(sys_rst),
        .cond(warn_raw_second),
        .bypass(st.warn_cfg[PRC_W2_NODEB_BIT]),
        .flag(warn_second)
    );

    assign temp_warn_first = warn_first;
    assign temp_warn_second = warn_second;

    // ==========================================================
    // ADC refresh period select
    // ==========================================================
    always_comb begin
        unique case (st.adc_rate[PRC_ADC_LSB+:2])
            2'h0: adc_period = ADC_10P5_CYC;
            2'h1: adc_period = ADC_52P4_CYC;
            2'h2: adc_period = ADC_104P9_CYC;
            2'h3: adc_period = ADC_209P7_CYC;
        endcase
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        next_st = st;

        // Go bits drop once started; a write in that cycle still wins
        if (begun_a) begin
            next_st.restart_ctrl[PRC_GO_A_BIT] = 1'b0;
        end
        if (begun_b) begin
            next_st.restart_ctrl[PRC_GO_B_BIT] = 1'b0;
        end

        // Whole bytes stored, reserved bits too
        if (wr_restart) begin
            next_st.restart_ctrl = reg_wdata;
        end
        if (wr_adc) begin
            next_st.adc_rate = reg_wdata;
        end
        if (wr_warn) begin
            next_st.warn_cfg = reg_wdata;
        end

        // Read data is registered; unmapped addresses read zero
        if (reg_rd) begin
            unique case (reg_addr)
                PRC_OFS_RESTART: next_st.rdata = st.restart_ctrl;
                PRC_OFS_ADC_RATE: next_st.rdata = st.adc_rate;
                PRC_OFS_WARN: next_st.rdata = st.warn_cfg;
                default: next_st.rdata = PRC_RST_RDATA;
            endcase
        end

        // Refresh tick; >= lets a shorter new period take effect at once
        next_st.adc_strobe = 1'b0;
        if (st.adc_cnt >= adc_period - 1'b1) begin
            next_st.adc_cnt = '0;
            next_st.adc_strobe = 1'b1;
        end else begin
            next_st.adc_cnt = st.adc_cnt + 1'b1;
        end

        // Faults; own off phase counts as supply off
        next_st.pg_fault_a = flags_chan_a.undervoltage
            || flags_chan_a.supply_off || seq_off_a
            || config_crc_flag || flags_chan_a.softstart_filter
            || (st.warn_cfg[PRC_W1_PG_BIT] && warn_first);
        next_st.pg_fault_b = flags_chan_b.undervoltage
            || flags_chan_b.supply_off || seq_off_b
            || config_crc_flag || flags_chan_b.softstart_filter
            || (st.warn_cfg[PRC_W2_PG_BIT] && warn_second);

        // Pin low in the same cycle as the fault
        next_st.pg_pin_a = !next_st.pg_fault_a;
        next_st.pg_pin_b = !next_st.pg_fault_b;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.restart_ctrl <= PRC_RST_RESTART;
            st.adc_rate <= PRC_RST_ADC_RATE;
            st.warn_cfg <= PRC_RST_WARN;
            st.rdata <= PRC_RST_RDATA;
            st.pg_pin_a <= 1'b1;
            st.pg_pin_b <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign reg_rdata = st.rdata;
    assign current_adc_refresh = st.adc_strobe;
    assign power_good_fault_chan_a = st.pg_fault_a;
    assign power_good_fault_chan_b = st.pg_fault_b;
    assign power_good_pin_chan_a = st.pg_pin_a;
    assign power_good_pin_chan_b = st.pg_pin_b;

endmodule

// ### sim/prc_top_properties.sv
`timescale 1ns/1ps
module prc_top_props
    import prc_pkg::*;
#(
    parameter logic [PRC_CNT_W-1:0] RESTART_500MS_CYC = 27'h1,
    parameter logic [PRC_CNT_W-1:0] RESTART_1S_CYC = 27'h2,
    parameter logic [PRC_CNT_W-1:0] RESTART_2S_CYC = 27'h3,
    parameter logic [PRC_CNT_W-1:0] DEB_100MS_CYC = 27'h1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [PRC_TEMP_W-1:0] temp_sense_first,
    input wire logic [PRC_TEMP_W-1:0] overtemp_protect_first,
    input wire prc_chan_flags_t flags_chan_a,
    input wire logic config_crc_flag,
    input wire logic supply_off_chan_a,
    input wire logic supply_off_chan_b,
    input wire logic current_adc_refresh,
    input wire logic temp_warn_first,
    input wire logic power_good_fault_chan_a,
    input wire logic power_good_fault_chan_b,
    input wire logic power_good_pin_chan_a,
    input wire logic power_good_pin_chan_b
);
    // ==========================================================
    // Shadow registers and counters
    // ==========================================================
    logic [7:0] rst_sh;
    logic [7:0] warn_sh;
    logic [PRC_CNT_W-1:0] dly_cyc, off_exp, off_len, run1;
    logic cond1;

    // Widened so the sum cannot wrap
    assign cond1 = {1'b0, temp_sense_first} >= {1'b0, overtemp_protect_first}
        + 13'(warn_sh[1:0]) + 13'h1;

    // Wait chosen by the delay field
    always_comb begin
        case (rst_sh[3:2])
            2'h0: dly_cyc = '0;
            2'h1: dly_cyc = RESTART_500MS_CYC;
            2'h2: dly_cyc = RESTART_1S_CYC;
            default: dly_cyc = RESTART_2S_CYC;
        endcase
    end

    // Expected wait frozen while channel A is off
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sh <= 8'h00;
            warn_sh <= 8'h00;
            off_exp <= '0;
            off_len <= '0;
            run1 <= '0;
        end else begin
            if (reg_wr && reg_addr == PRC_OFS_RESTART) rst_sh <= reg_wdata;
            if (reg_wr && reg_addr == PRC_OFS_WARN) warn_sh <= reg_wdata;
            if (!supply_off_chan_a) off_exp <= dly_cyc;
            off_len <= supply_off_chan_a ? off_len + 27'h1 : '0;
            run1 <= cond1 ? run1 + 27'h1 : '0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Assertions
    // ==========================================================
    a_pin_inverse: assert property (power_good_pin_chan_a ==
        !power_good_fault_chan_a && power_good_pin_chan_b ==
        !power_good_fault_chan_b)
        else $error("pin not inverse");
    a_uv_fault: assert property (flags_chan_a.undervoltage |=>
        power_good_fault_chan_a) else $error("uv no fault");
    a_crc_fault: assert property (config_crc_flag |=>
        power_good_fault_chan_a && power_good_fault_chan_b)
        else $error("crc no fault");
    a_off_fault: assert property (supply_off_chan_a |=>
        power_good_fault_chan_a) else $error("off no fault");
    a_restart_a: assert property (reg_wr && reg_addr == PRC_OFS_RESTART
        && reg_wdata[0] && !supply_off_chan_a |-> ##[1:2] supply_off_chan_a)
        else $error("A no restart");
    a_restart_b: assert property (reg_wr && reg_addr == PRC_OFS_RESTART
        && reg_wdata[1] && !supply_off_chan_b |-> ##[1:2] supply_off_chan_b)
        else $error("B no restart");
    a_off_length: assert property ($fell(supply_off_chan_a) |->
        off_len == off_exp + 27'h1) else $error("off length");
    // Shortest refresh period in this bench is eight cycles
    a_adc_gap: assert property (current_adc_refresh |=>
        !current_adc_refresh [*7]) else $error("refresh gap");
    a_warn_debounce: assert property ($rose(temp_warn_first) &&
        !warn_sh[3] |-> run1 >= DEB_100MS_CYC - 27'h1)
        else $error("early warning");
    a_warn_drop: assert property (!cond1 [*2] |=> !temp_warn_first)
        else $error("warning held");
    a_warn_route: assert property (warn_sh[2] && temp_warn_first |=>
        power_good_fault_chan_a) else $error("warn no fault");

    c_long_off: cover property ($fell(supply_off_chan_a) &&
        off_len > RESTART_1S_CYC);
    c_deb_warn: cover property ($rose(temp_warn_first) && !warn_sh[3]);
    c_refresh: cover property (current_adc_refresh ##8 current_adc_refresh);
endmodule

bind prc_top prc_top_props #(
    .RESTART_500MS_CYC(RESTART_500MS_CYC),
    .RESTART_1S_CYC(RESTART_1S_CYC),
    .RESTART_2S_CYC(RESTART_2S_CYC),
    .DEB_100MS_CYC(DEB_100MS_CYC)
) prc_top_props_inst (
    .clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .temp_sense_first,
    .overtemp_protect_first, .flags_chan_a, .config_crc_flag,
    .supply_off_chan_a, .supply_off_chan_b, .current_adc_refresh,
    .temp_warn_first, .power_good_fault_chan_a, .power_good_fault_chan_b,
    .power_good_pin_chan_a, .power_good_pin_chan_b
);

// ### sim/prc_host_model.sv
`timescale 1ns/1ps
module prc_host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Start idle; later idle shows inverted values
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end

    // One-cycle write strobe from the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Read data taken a cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule

// ### sim/prc_top_test.sv
`timescale 1ns/1ps
module prc_top_test
    import prc_pkg::*;
;
    // ==========================================================
    // Short counts so the whole run stays small
    // ==========================================================
    localparam int RST_N [4] = '{0, 10, 20, 40};
    localparam int ADC_P [4] = '{8, 16, 24, 32};
    localparam int DEB = 6;
    logic [31:0] rows [11] = '{32'hFE890303, 32'hFE89FCFC, 32'hFE8AA5A5,
        32'hFE8A5A5A, 32'hFE88F0F0, 32'hFE880C0C, 32'hFE8B7700,
        32'hFE871200, 32'hFE880000, 32'hFE8A0000, 32'hFE890000};

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr, reg_rd, config_crc_flag;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [PRC_TEMP_W-1:0] temp_sense_first, temp_sense_second;
    logic [PRC_TEMP_W-1:0] overtemp_protect_first, overtemp_protect_second;
    prc_chan_flags_t flags_chan_a, flags_chan_b;
    logic supply_off_chan_a, supply_off_chan_b, current_adc_refresh;
    logic temp_warn_first, temp_warn_second;
    logic power_good_fault_chan_a, power_good_fault_chan_b;
    logic power_good_pin_chan_a, power_good_pin_chan_b;
    int fails = 0;
    int checks = 0;
    int k, o;

    prc_top #(
        .RESTART_500MS_CYC(PRC_CNT_W'(RST_N[1])),
        .RESTART_1S_CYC(PRC_CNT_W'(RST_N[2])),
        .RESTART_2S_CYC(PRC_CNT_W'(RST_N[3])),
        .ADC_10P5_CYC(PRC_CNT_W'(ADC_P[0])),
        .ADC_52P4_CYC(PRC_CNT_W'(ADC_P[1])),
        .ADC_104P9_CYC(PRC_CNT_W'(ADC_P[2])),
        .ADC_209P7_CYC(PRC_CNT_W'(ADC_P[3])),
        .DEB_100MS_CYC(PRC_CNT_W'(DEB))
    ) prc_top_inst (
        .clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .temp_sense_first, .temp_sense_second, .overtemp_protect_first,
        .overtemp_protect_second, .flags_chan_a, .flags_chan_b,
        .config_crc_flag, .supply_off_chan_a, .supply_off_chan_b,
        .current_adc_refresh, .temp_warn_first, .temp_warn_second,
        .power_good_fault_chan_a, .power_good_fault_chan_b,
        .power_good_pin_chan_a, .power_good_pin_chan_b
    );

    prc_host_model prc_host_model_inst (
        .clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
    );

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Set both sense codes, wait, compare flags and faults
    task automatic warn(input logic [11:0] s1, s2, input int n,
        input logic [3:0] e);
        @(negedge clk);
        temp_sense_first = s1;
        temp_sense_second = s2;
        repeat (n) @(negedge clk);
        chk("warn", e, {temp_warn_first, temp_warn_second,
            power_good_fault_chan_a, power_good_fault_chan_b});
    endtask

    // Watchdog at 20000 cycles, tests need under a thousand cycles
    initial begin
        #(25 * 20000);
        fails++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {temp_sense_first, temp_sense_second} = '0;
        overtemp_protect_first = 12'h064;
        overtemp_protect_second = 12'h0C8;
        {config_crc_flag, flags_chan_b, flags_chan_a} = 7'h00;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        for (int a = 0; a < 3; a++) begin
            prc_host_model_inst.rd(16'hFE88 + 16'(a), rv);
            chk("reset_val", 8'h00, rv);
        end
        // First pass checks the reset rate
        for (int s = 0; s < 4; s++) begin
            if (s > 0) prc_host_model_inst.wr(PRC_OFS_ADC_RATE, 8'(s));
            repeat (2) begin
                k = 0;
                do begin
                    @(negedge clk);
                    k++;
                end while (current_adc_refresh !== 1'b1 && k < 100);
            end
            chk("adc_period", ADC_P[s], k);
        end
        foreach (rows[i]) begin
            prc_host_model_inst.wr(rows[i][31:16], rows[i][15:8]);
            prc_host_model_inst.rd(rows[i][31:16], rv);
            chk("reg", rows[i][7:0], rv);
        end
        // Every delay on both channels; the other channel must stay on
        for (int i = 0; i < 8; i++) begin
            prc_host_model_inst.wr(PRC_OFS_RESTART,
                {4'h0, 2'(i >> 1), i[0] ? 2'b10 : 2'b01});
            k = 0;
            o = 0;
            repeat (60) begin
                @(negedge clk);
                k += ((i[0] ? supply_off_chan_b : supply_off_chan_a) === 1'b1);
                o += ((i[0] ? supply_off_chan_a : supply_off_chan_b) !== 1'b0);
            end
            chk("off_len", RST_N[i >> 1] + 1, k);
            chk("other_off", 0, o);
            prc_host_model_inst.rd(PRC_OFS_RESTART, rv);
            chk("go_clear", {4'h0, 2'(i >> 1), 2'b00}, rv);
        end
        // Each fault source alone, then checksum
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            {config_crc_flag, flags_chan_b, flags_chan_a} = 7'h01 << i;
            repeat (2) @(negedge clk);
            chk("fault_a", i < 3 || i == 6, power_good_fault_chan_a);
            chk("fault_b", i > 2, power_good_fault_chan_b);
            chk("pins", {!(i < 3 || i == 6), i < 3},
                {power_good_pin_chan_a, power_good_pin_chan_b});
        end
        {config_crc_flag, flags_chan_b, flags_chan_a} = 7'h00;
        // No debounce, routed, thresholds 103 and 202
        prc_host_model_inst.wr(PRC_OFS_WARN, 8'hDE);
        warn(12'h066, 12'h0C9, 4, 4'b0000);
        warn(12'h067, 12'h0C9, 4, 4'b1010);
        warn(12'h067, 12'h0CA, 4, 4'b1111);
        warn(12'h000, 12'h000, 4, 4'b0000);
        // Debounced, not routed, thresholds 101 and 201
        prc_host_model_inst.wr(PRC_OFS_WARN, 8'h00);
        warn(12'h065, 12'h0C9, DEB - 2, 4'b0000);
        warn(12'h000, 12'h000, 1, 4'b0000);
        warn(12'h065, 12'h0C9, DEB - 1, 4'b0000);
        warn(12'h065, 12'h0C9, DEB - 1, 4'b1100);
        warn(12'h000, 12'h000, 4, 4'b0000);
        // Reset during a long restart
        prc_host_model_inst.wr(PRC_OFS_RESTART, 8'h0D);
        repeat (5) @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        chk("rst_off", 0, supply_off_chan_a);
        chk("rst_pin", 1, power_good_pin_chan_a);
        sys_rst = 1'b0;
        prc_host_model_inst.rd(PRC_OFS_RESTART, rv);
        chk("rst_reg", 8'h00, rv);
        summarize();
    end
endmodule
